// ---- dv/sdb_ctrl_model.sv ----
// controller-side model issuing load, activate, access and terminate commands
`timescale 1ns/1ps
module sdb_ctrl_model (
	input wire logic i_ref_clk,
	output sdb_pkg::sdb_cmd_t o_cmd
);
	// ==========================================================
	// command issue
	initial o_cmd = '1;

	// deselected cycles drive NOP with the inverse of the last bank and address so stale values never look valid
	task automatic issue(input logic [2:0] code, input logic [1:0] ba, input logic [12:0] a);
		@(posedge i_ref_clk);
		o_cmd <= {1'b0, code, ba, a};
		@(posedge i_ref_clk);
		o_cmd <= {1'b1, 3'h7, ~ba, ~a};
	endtask : issue

	task automatic setup(input sdb_pkg::sdb_cfg_t cfg);
		issue(sdb_pkg::CMD_PRECHARGE, 2'h0, 13'h0400);
		repeat (sdb_pkg::RC_CYC) @(posedge i_ref_clk);
		issue(sdb_pkg::CMD_LOAD, 2'h0, {3'h0, cfg});
		repeat (sdb_pkg::CFG_RECOVERY_CYC) @(posedge i_ref_clk);
		issue(sdb_pkg::CMD_ACTIVE, 2'h1, 13'h0123);
		repeat (sdb_pkg::RCD_CYC) @(posedge i_ref_clk);
	endtask : setup

	task automatic rd(input logic [9:0] col);
		issue(sdb_pkg::CMD_READ, 2'h1, {3'h0, col});
	endtask : rd

	task automatic wr(input logic [9:0] col);
		issue(sdb_pkg::CMD_WRITE, 2'h1, {3'h0, col});
	endtask : wr

	task automatic term();
		issue(sdb_pkg::CMD_TERM, 2'h1, 13'h0000);
	endtask : term
endmodule : sdb_ctrl_model

// ---- dv/test_sdram_mode_burst_activation.sv ----
// self-checking bench for the configuration, burst and activation block
`timescale 1ns/1ps
module test_sdram_mode_burst_activation;
	// ==========================================================
	// signals and instances
	logic ref_clk = 1'b0;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic wr_beat;
	logic [9:0] wr_col;
	logic dq_oe;
	logic [9:0] rd_col;
	logic [3:0] bank_open;
	sdb_pkg::sdb_cmd_t cmd;
	int err_total = 0;
	int num_checks = 0;

	always #4 ref_clk = ~ref_clk;

	sdb_ctrl_model sdb_ctrl_model_inst (.i_ref_clk(ref_clk), .o_cmd(cmd));
	sdb_mode_burst #(.COL_W(10)) sdb_mode_burst_inst (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_cmd(cmd), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_wr_beat(wr_beat), .o_wr_col(wr_col), .o_dq_oe(dq_oe), .o_rd_col(rd_col),
		.o_bank_open(bank_open)
	);

	// ==========================================================
	// helpers
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
		num_checks++;
		if (got !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, x, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic er);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdreg(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic er;
		apb(1'b0, a, 32'h0, q, er);
		chk(nm, x, q & m);
		chk("pslverr", {31'h0, xe}, {31'h0, er});
	endtask : rdreg

	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic er;
		apb(1'b1, a, d, q, er);
		chk("pslverr_wr", 32'h0, {31'h0, er});
	endtask : wreg

	// columns are worked out from span, order and start; a page burst has no end check
	task automatic chk_burst(input logic is_rd, input sdb_pkg::sdb_cfg_t c, input logic [9:0] col, input int n);
		logic [9:0] m;
		logic [9:0] e;
		case (c.burst_span)
			sdb_pkg::SPAN_2: m = 10'h001;
			sdb_pkg::SPAN_4: m = 10'h003;
			sdb_pkg::SPAN_8: m = 10'h007;
			sdb_pkg::SPAN_PAGE: m = 10'h3ff;
			default: m = 10'h000;
		endcase
		if (is_rd && c.read_delay_setting == sdb_pkg::DELAY_3) begin
			@(posedge ref_clk);
			#1;
			chk("oe_early", 32'h0, {31'h0, dq_oe});
		end
		for (int k = 0; k < n; k++) begin
			if (is_rd || k > 0) begin
				@(posedge ref_clk);
			end
			#1;
			e = (c.burst_order_bit && c.burst_span != sdb_pkg::SPAN_PAGE) ? (col ^ 10'(k)) : (col + 10'(k));
			e = (col & ~m) | (e & m);
			chk(is_rd ? "rd_beat" : "wr_beat", 32'h1, {31'h0, is_rd ? dq_oe : wr_beat});
			chk(is_rd ? "rd_col" : "wr_col", {22'h0, e}, {22'h0, is_rd ? rd_col : wr_col});
		end
		if (c.burst_span != sdb_pkg::SPAN_PAGE) begin
			@(posedge ref_clk);
			#1;
			chk("burst_end", 32'h0, {31'h0, is_rd ? dq_oe : wr_beat});
		end
	endtask : chk_burst

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rdreg("cfg_reset", sdb_pkg::REG_CONFIG, 32'hffffffff, {22'h0, sdb_pkg::CFG_RESET}, 1'b0);
		rdreg("status_reset", sdb_pkg::REG_STATUS, 32'hffffffff, 32'h0, 1'b0);
		rdreg("unmapped", 12'h008, 32'hffffffff, 32'h0, 1'b1);
		wreg(sdb_pkg::REG_CONFIG, 32'hffff_fc22);
		rdreg("cfg_apb", sdb_pkg::REG_CONFIG, 32'hffffffff, 32'h0000_0022, 1'b0);
	endtask : t_reset

	task automatic t_bursts();
		sdb_pkg::sdb_cfg_t tbl [8] = '{10'h021, 10'h029, 10'h022, 10'h02a, 10'h023, 10'h02b, 10'h028, 10'h032};
		foreach (tbl[i]) begin
			sdb_ctrl_model_inst.setup(tbl[i]);
			chk("bank_open", 32'h2, {28'h0, bank_open});
			sdb_ctrl_model_inst.rd(10'h2d5);
			chk_burst(1'b1, tbl[i], 10'h2d5, 1 << tbl[i].burst_span);
			rdreg("cfg_held", sdb_pkg::REG_CONFIG, 32'hffffffff, {22'h0, tbl[i]}, 1'b0);
		end
	endtask : t_bursts

	task automatic t_wmode();
		sdb_ctrl_model_inst.setup(10'h022);
		sdb_ctrl_model_inst.wr(10'h01e);
		chk_burst(1'b0, 10'h022, 10'h01e, 4);
		sdb_ctrl_model_inst.setup(10'h222);
		sdb_ctrl_model_inst.wr(10'h01e);
		chk_burst(1'b0, 10'h222, 10'h01e, 1);
		sdb_ctrl_model_inst.rd(10'h01e);
		chk_burst(1'b1, 10'h222, 10'h01e, 4);
	endtask : t_wmode

	task automatic t_page();
		sdb_ctrl_model_inst.setup(10'h027);
		sdb_ctrl_model_inst.rd(10'h3fe);
		chk_burst(1'b1, 10'h027, 10'h3fe, 5);
		sdb_ctrl_model_inst.term();
		repeat (4) @(posedge ref_clk);
		#1;
		chk("page_end", 32'h0, {31'h0, dq_oe});
		sdb_ctrl_model_inst.setup(10'h02f);
		sdb_ctrl_model_inst.rd(10'h3fe);
		chk_burst(1'b1, 10'h02f, 10'h3fe, 3);
		sdb_ctrl_model_inst.term();
		rdreg("status_page", sdb_pkg::REG_STATUS, 32'h7f, 32'h40, 1'b0);
		wreg(sdb_pkg::REG_STATUS, 32'h0000_0040);
	endtask : t_page

	// deliberate controller-side violations, each must leave its sticky flag
	task automatic t_timing();
		sdb_ctrl_model_inst.setup(10'h020);
		sdb_ctrl_model_inst.issue(sdb_pkg::CMD_ACTIVE, 2'h2, 13'h0010);
		sdb_ctrl_model_inst.issue(sdb_pkg::CMD_READ, 2'h2, 13'h0000);
		sdb_ctrl_model_inst.issue(sdb_pkg::CMD_ACTIVE, 2'h1, 13'h0020);
		sdb_ctrl_model_inst.issue(sdb_pkg::CMD_READ, 2'h0, 13'h0000);
		sdb_ctrl_model_inst.issue(sdb_pkg::CMD_LOAD, 2'h0, 13'h0020);
		chk("bank_open_multi", 32'h6, {28'h0, bank_open});
		rdreg("status_timing", sdb_pkg::REG_STATUS, 32'hf7f, 32'h62b, 1'b0);
		wreg(sdb_pkg::REG_STATUS, 32'h0000_007f);
		rdreg("status_timing_clr", sdb_pkg::REG_STATUS, 32'h7f, 32'h0, 1'b0);
	endtask : t_timing

	task automatic t_status();
		sdb_ctrl_model_inst.setup(10'h0a0);
		rdreg("status_mode", sdb_pkg::REG_STATUS, 32'h7f, 32'h40, 1'b0);
		wreg(sdb_pkg::REG_STATUS, 32'h0000_0040);
		rdreg("status_clear", sdb_pkg::REG_STATUS, 32'h7f, 32'h0, 1'b0);
		sdb_ctrl_model_inst.setup(10'h020);
		rdreg("status_normal", sdb_pkg::REG_STATUS, 32'h7f, 32'h0, 1'b0);
	endtask : t_status

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_bursts();
		t_wmode();
		t_page();
		t_timing();
		t_status();
		end_of_test();
	end

	// the full sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		end_of_test();
	end
endmodule : test_sdram_mode_burst_activation

// ---- verilog/sdb_mode_burst.sv ----
// configuration store, burst column sequencer, read delay and row activation checks
`timescale 1ns/1ps

// Behaviour
// - configuration is stored on a load command with bank zero or an apb write and held until the next such load or write
// - word fields: span 2:0, order 3, read delay 6:4, mode 8:7, write mode 9
// - spans 1, 2, 4, 8 in both orders; full page sequential only
// - burst stays in an aligned block of span columns, wrapping at its edge
// - page is 2048, 1024 or 512 columns depending on organization
// - sequential adds a count to low bits, interleaved xors it
// - full page burst is sequential only, interleave is not supported there
// - full page burst runs on, wrapping from last column to zero, until stopped
// - span one accesses the addressed column only, order bit ignored
// - read delay is two or three clocks
// - read at edge n drives from edge n+m-1, data valid by edge n+m
// - both mode bits zero is normal operation, other values are reserved
// - write mode bit set makes every write a single location access
module sdb_mode_burst #(
	parameter int COL_W = 10
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire sdb_pkg::sdb_cmd_t i_cmd,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_wr_beat,
	output logic [COL_W-1:0] o_wr_col,
	output logic o_dq_oe,
	output logic [COL_W-1:0] o_rd_col,
	output logic [3:0] o_bank_open
);

	// ==========================================================
	// functions
	function automatic logic [2:0] span_mask(input logic [2:0] span);
		case (span)
			sdb_pkg::SPAN_2: span_mask = 3'h1;
			sdb_pkg::SPAN_4: span_mask = 3'h3;
			sdb_pkg::SPAN_8: span_mask = 3'h7;
			default: span_mask = 3'h0;
		endcase
	endfunction : span_mask

	// x4 pages skip address bit 10, which carries the precharge-all flag
	function automatic logic [COL_W-1:0] cap_col(input logic [12:0] addr);
		logic [10:0] packed_col;
		packed_col = {addr[11], addr[9:0]};
		cap_col = (COL_W == 11) ? packed_col[COL_W-1:0] : addr[COL_W-1:0];
	endfunction : cap_col

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		sat_inc = (v == sdb_pkg::CNT_SAT) ? v : 8'(v + 8'h01);
	endfunction : sat_inc

	// ==========================================================
	// command decode
	logic [2:0] cmd_code;
	logic cmd_valid;
	logic cmd_load;
	logic cmd_act;
	logic cmd_read;
	logic cmd_write;
	logic cmd_term;
	logic cmd_pre;
	logic load_ok;
	logic [COL_W-1:0] cmd_col;

	assign cmd_code = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
	assign cmd_valid = !i_cmd.cs_n && cmd_code != sdb_pkg::CMD_NOP;
	assign cmd_load = !i_cmd.cs_n && cmd_code == sdb_pkg::CMD_LOAD;
	assign cmd_act = !i_cmd.cs_n && cmd_code == sdb_pkg::CMD_ACTIVE;
	assign cmd_read = !i_cmd.cs_n && cmd_code == sdb_pkg::CMD_READ;
	assign cmd_write = !i_cmd.cs_n && cmd_code == sdb_pkg::CMD_WRITE;
	assign cmd_term = !i_cmd.cs_n && cmd_code == sdb_pkg::CMD_TERM;
	assign cmd_pre = !i_cmd.cs_n && cmd_code == sdb_pkg::CMD_PRECHARGE;
	// a load with nonzero bank selects addresses another word and is ignored
	assign load_ok = cmd_load && i_cmd.ba == 2'h0;
	assign cmd_col = cap_col(i_cmd.addr);

	// ==========================================================
	// apb slave, zero wait states
	logic apb_setup;
	logic apb_acc;
	logic apb_hit;
	logic apb_cfg_wr;
	logic apb_st_wr;

	assign apb_setup = i_psel && !i_penable;
	assign apb_acc = i_psel && i_penable;
	assign apb_hit = i_paddr == sdb_pkg::REG_CONFIG || i_paddr == sdb_pkg::REG_STATUS;
	assign apb_cfg_wr = apb_acc && i_pwrite && i_paddr == sdb_pkg::REG_CONFIG;
	assign apb_st_wr = apb_acc && i_pwrite && i_paddr == sdb_pkg::REG_STATUS;
	assign o_pready = apb_acc;
	assign o_pslverr = apb_acc && !apb_hit;

	// ==========================================================
	// configuration store
	sdb_pkg::sdb_cfg_t cfg;
	logic cfg_lat3;

	// unrecognised delay codes run as three clocks, the safer of the two
	assign cfg_lat3 = cfg.read_delay_setting != sdb_pkg::DELAY_2;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cfg <= sdb_pkg::CFG_RESET;
		end else if (load_ok) begin
			cfg <= i_cmd.addr[sdb_pkg::CFG_W-1:0];
		end else if (apb_cfg_wr) begin
			cfg <= i_pwdata[sdb_pkg::CFG_W-1:0];
		end
	end

	// ==========================================================
	// burst sequencer
	sdb_pkg::sdb_state_t state;
	logic beat;
	logic is_wr;
	logic [COL_W-1:0] col;
	logic [2:0] start;
	logic [2:0] cnt;
	logic [2:0] span;
	logic order;
	logic [1:0] bank;
	logic [2:0] mask;
	logic at_last;
	logic start_any;
	logic stop_any;
	logic cont;
	logic [2:0] next_low;

	assign mask = span_mask(span);
	assign at_last = span != sdb_pkg::SPAN_PAGE && cnt == mask;
	assign start_any = cmd_read || cmd_write;
	assign stop_any = cmd_term || (cmd_pre && (i_cmd.addr[sdb_pkg::ALL_BANKS_BIT] || i_cmd.ba == bank));
	assign cont = state == sdb_pkg::SDB_BURST && !start_any && !stop_any && !at_last;
	assign next_low = order ? (start ^ 3'(cnt + 3'h1)) : 3'(start + cnt + 3'h1);

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state <= sdb_pkg::SDB_IDLE;
			beat <= 1'b0;
			is_wr <= 1'b0;
			col <= '0;
			start <= 3'h0;
			cnt <= 3'h0;
			span <= sdb_pkg::SPAN_1;
			order <= 1'b0;
			bank <= 2'h0;
		end else if (start_any) begin
			// a new access truncates whatever burst is running
			state <= sdb_pkg::SDB_BURST;
			beat <= 1'b1;
			is_wr <= cmd_write;
			col <= cmd_col;
			start <= cmd_col[2:0];
			cnt <= 3'h0;
			span <= (cmd_write && cfg.write_single_bit) ? sdb_pkg::SPAN_1 : cfg.burst_span;
			order <= cfg.burst_order_bit;
			bank <= i_cmd.ba;
		end else begin
			unique case (state)
				sdb_pkg::SDB_IDLE: begin
					beat <= 1'b0;
				end
				sdb_pkg::SDB_BURST: begin
					if (stop_any || at_last) begin
						state <= sdb_pkg::SDB_IDLE;
						beat <= 1'b0;
					end else begin
						cnt <= 3'(cnt + 3'h1);
						if (span == sdb_pkg::SPAN_PAGE) begin
							col <= COL_W'(col + 1'b1);
						end else begin
							col <= {col[COL_W-1:3], (col[2:0] & ~mask) | (next_low & mask)};
						end
					end
				end
			endcase
		end
	end

	assign o_wr_beat = beat && is_wr;
	assign o_wr_col = col;

	// ==========================================================
	// read delay pipe
	logic rd_s1_v;
	logic [COL_W-1:0] rd_s1_col;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rd_s1_v <= 1'b0;
			rd_s1_col <= '0;
			o_dq_oe <= 1'b0;
			o_rd_col <= '0;
		end else begin
			rd_s1_v <= beat && !is_wr;
			rd_s1_col <= col;
			o_dq_oe <= cfg_lat3 ? rd_s1_v : (beat && !is_wr);
			o_rd_col <= cfg_lat3 ? rd_s1_col : col;
		end
	end

	// ==========================================================
	// row activation tracking and timing watch
	logic [3:0] bank_open;
	logic [7:0] since_act [4];
	logic [7:0] since_any;
	logic [7:0] since_load;
	logic [sdb_pkg::ST_FLAGS-1:0] flags;
	logic [sdb_pkg::ST_FLAGS-1:0] flag_set;
	logic cfg_bad;

	assign o_bank_open = bank_open;
	assign cfg_bad = {i_cmd.addr[8], i_cmd.addr[7]} != sdb_pkg::OPMODE_NORMAL
		|| !(i_cmd.addr[2:0] inside {sdb_pkg::SPAN_1, sdb_pkg::SPAN_2, sdb_pkg::SPAN_4, sdb_pkg::SPAN_8,
			sdb_pkg::SPAN_PAGE})
		|| !(i_cmd.addr[6:4] inside {sdb_pkg::DELAY_2, sdb_pkg::DELAY_3})
		|| (i_cmd.addr[3] && i_cmd.addr[2:0] == sdb_pkg::SPAN_PAGE);

	always_comb begin
		flag_set = '0;
		flag_set[sdb_pkg::ST_RCD] = start_any && since_act[i_cmd.ba] < sdb_pkg::RCD_CNT;
		flag_set[sdb_pkg::ST_CLOSED] = start_any && !bank_open[i_cmd.ba];
		flag_set[sdb_pkg::ST_RC] = cmd_act && (since_act[i_cmd.ba] < sdb_pkg::RC_CNT || bank_open[i_cmd.ba]);
		flag_set[sdb_pkg::ST_RRD] = cmd_act && since_any < sdb_pkg::RRD_CNT;
		flag_set[sdb_pkg::ST_BUSY] = load_ok && |bank_open;
		flag_set[sdb_pkg::ST_MRD] = cmd_valid && since_load < sdb_pkg::MRD_CNT;
		flag_set[sdb_pkg::ST_RESERVED] = load_ok && cfg_bad;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			bank_open <= 4'h0;
		end else if (cmd_act) begin
			bank_open[i_cmd.ba] <= 1'b1;
		end else if (cmd_pre) begin
			if (i_cmd.addr[sdb_pkg::ALL_BANKS_BIT]) begin
				bank_open <= 4'h0;
			end else begin
				bank_open[i_cmd.ba] <= 1'b0;
			end
		end
	end

	// counters hold edges since the event; saturated means long ago
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			for (int b = 0; b < 4; b++) begin
				since_act[b] <= sdb_pkg::CNT_SAT;
			end
			since_any <= sdb_pkg::CNT_SAT;
			since_load <= sdb_pkg::CNT_SAT;
		end else begin
			for (int b = 0; b < 4; b++) begin
				since_act[b] <= (cmd_act && i_cmd.ba == 2'(b)) ? 8'h01 : sat_inc(since_act[b]);
			end
			since_any <= cmd_act ? 8'h01 : sat_inc(since_any);
			since_load <= load_ok ? 8'h01 : sat_inc(since_load);
		end
	end

	// sticky, write one to clear; a new event wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~(apb_st_wr ? i_pwdata[sdb_pkg::ST_FLAGS-1:0] : '0)) | flag_set;
		end
	end

	// read data is captured in the setup cycle
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_prdata <= 32'h0;
		end else if (apb_setup && !i_pwrite) begin
			if (i_paddr == sdb_pkg::REG_CONFIG) begin
				o_prdata <= 32'(cfg);
			end else if (i_paddr == sdb_pkg::REG_STATUS) begin
				o_prdata <= 32'({is_wr, state == sdb_pkg::SDB_BURST, bank_open, 1'b0, flags});
			end else begin
				o_prdata <= 32'h0;
			end
		end
	end

	// ==========================================================
	// assertions
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_read_quiet;
		!beat && !rd_s1_v && !o_dq_oe;
	endsequence

	sequence s_read_lat2;
		(cmd_read && !cfg_lat3 && !load_ok && !apb_cfg_wr) and s_read_quiet;
	endsequence

	sequence s_read_lat3;
		(cmd_read && cfg_lat3 && !load_ok && !apb_cfg_wr) and s_read_quiet;
	endsequence

	a_cfg_capture: assert property (load_ok |=> cfg == $past(i_cmd.addr[9:0]))
		else $error("configuration not captured from address");
	a_cfg_hold: assert property (!load_ok && !apb_cfg_wr |=> $stable(cfg))
		else $error("configuration changed without a load");
	// the enable flops on edge n+m-1, so it is seen sampled one edge later
	a_read_two: assert property (s_read_lat2 |=> ##1 o_dq_oe && o_rd_col == $past(cmd_col, 2))
		else $error("read data not driven one edge after read at delay two");
	a_read_three: assert property (s_read_lat3 ##1 !load_ok && !apb_cfg_wr
		|=> ##1 o_dq_oe && o_rd_col == $past(cmd_col, 3))
		else $error("read data not driven two edges after read at delay three");
	a_read_early: assert property (s_read_lat3 |=> ##1 !o_dq_oe)
		else $error("read data driven early at delay three");
	a_block_stay: assert property (cont && span != sdb_pkg::SPAN_PAGE |=> col[COL_W-1:3] == $past(col[COL_W-1:3]))
		else $error("fixed burst left its block");
	a_seq_order: assert property (state == sdb_pkg::SDB_BURST && !order && span != sdb_pkg::SPAN_PAGE
		|-> (col[2:0] & mask) == (3'(start + cnt) & mask))
		else $error("sequential column order wrong");
	a_inter_order: assert property (state == sdb_pkg::SDB_BURST && order && span != sdb_pkg::SPAN_PAGE
		|-> (col[2:0] & mask) == ((start ^ cnt) & mask))
		else $error("interleaved column order wrong");
	a_page_wrap: assert property (cont && span == sdb_pkg::SPAN_PAGE && col == '1 |=> col == '0)
		else $error("page burst did not wrap to column zero");
	a_write_single: assert property ((cmd_write && cfg.write_single_bit) ##1 !start_any
		|=> state == sdb_pkg::SDB_IDLE && !beat)
		else $error("single write ran more than one beat");
	a_mode_flag: assert property (load_ok && {i_cmd.addr[8], i_cmd.addr[7]} != 2'h0
		|=> flags[sdb_pkg::ST_RESERVED])
		else $error("reserved mode not flagged");

endmodule : sdb_mode_burst

// ---- verilog/sdb_pkg.sv ----
// shared constants and types for the configuration, burst and activation block
package sdb_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_PS = 8000;
	localparam int ACT_TO_ACCESS_NS = 20;
	localparam int ACT_CYCLE_NS = 60;
	localparam int BANK_SPACING_NS = 15;
	localparam int RCD_CYC = (ACT_TO_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RC_CYC = (ACT_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RRD_CYC = (BANK_SPACING_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CFG_RECOVERY_CYC = 2;
	localparam logic [7:0] RCD_CNT = 8'(RCD_CYC);
	localparam logic [7:0] RC_CNT = 8'(RC_CYC);
	localparam logic [7:0] RRD_CNT = 8'(RRD_CYC);
	localparam logic [7:0] MRD_CNT = 8'(CFG_RECOVERY_CYC);
	localparam logic [7:0] CNT_SAT = 8'hff;

	// ==========================================================
	// configuration word
	localparam int CFG_W = 10;
	localparam logic [9:0] CFG_RESET = 10'h020;
	localparam logic [2:0] SPAN_1 = 3'h0;
	localparam logic [2:0] SPAN_2 = 3'h1;
	localparam logic [2:0] SPAN_4 = 3'h2;
	localparam logic [2:0] SPAN_8 = 3'h3;
	localparam logic [2:0] SPAN_PAGE = 3'h7;
	localparam logic [2:0] DELAY_2 = 3'h2;
	localparam logic [2:0] DELAY_3 = 3'h3;
	localparam logic [1:0] OPMODE_NORMAL = 2'h0;

	// ==========================================================
	// command codes on {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_LOAD = 3'h0;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_TERM = 3'h6;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam int ALL_BANKS_BIT = 10;

	// ==========================================================
	// register map
	localparam logic [11:0] REG_CONFIG = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam int ST_RCD = 0;
	localparam int ST_RC = 1;
	localparam int ST_RRD = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_MRD = 4;
	localparam int ST_CLOSED = 5;
	localparam int ST_RESERVED = 6;
	localparam int ST_FLAGS = 7;
	localparam int ST_OPEN_LSB = 8;
	localparam int ST_BURST = 12;
	localparam int ST_BURST_WR = 13;

	// ==========================================================
	// types
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] ba;
		logic [12:0] addr;
	} sdb_cmd_t;

	typedef struct packed {
		logic write_single_bit;
		logic op_mode_high_bit;
		logic op_mode_low_bit;
		logic [2:0] read_delay_setting;
		logic burst_order_bit;
		logic [2:0] burst_span;
	} sdb_cfg_t;

	typedef enum logic [1:0] {
		SDB_IDLE = 2'b01,
		SDB_BURST = 2'b10
	} sdb_state_t;

endpackage : sdb_pkg
